/* rtl/sbsr_pkg.sv */
// shared constants for the serial buffer and status register block
package sbsr_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_EVENTS  = 12'h004;
  localparam logic [11:0] OFF_CMD     = 12'h014;
  localparam logic [11:0] OFF_STATUS  = 12'h018;
  localparam logic [11:0] OFF_BAUD    = 12'h01c;
  localparam logic [11:0] OFF_RX_POPX = 12'h020;
  localparam logic [11:0] OFF_RX_POPB = 12'h024;
  localparam logic [11:0] OFF_RX_PRX  = 12'h028;
  localparam logic [11:0] OFF_RX_PRB  = 12'h02c;
  localparam logic [11:0] OFF_RX_PKX  = 12'h030;
  localparam logic [11:0] OFF_RX_PKPX = 12'h034;
  localparam logic [11:0] OFF_TX_PUSH = 12'h03c;

  // control register fields
  localparam int CTRL_AUTO_TRI  = 0;
  localparam int CTRL_LVL_SEL   = 1;
  localparam int CTRL_ASYNC     = 2;
  localparam int CTRL_IRDA      = 3;

  // command register fields
  localparam int CMD_RX_ON      = 0;
  localparam int CMD_RX_OFF     = 1;
  localparam int CMD_TX_ON      = 2;
  localparam int CMD_TX_OFF     = 3;
  localparam int CMD_MAIN_ON    = 4;
  localparam int CMD_MAIN_OFF   = 5;
  localparam int CMD_DISC_ON    = 6;
  localparam int CMD_DISC_OFF   = 7;
  localparam int CMD_TRI_ON     = 8;
  localparam int CMD_TRI_OFF    = 9;

  // status register fields
  localparam int ST_RX_ON       = 0;
  localparam int ST_TX_ON       = 1;
  localparam int ST_MAIN        = 2;
  localparam int ST_DISCARD     = 3;
  localparam int ST_TRI         = 4;
  localparam int ST_TX_COMPLETE = 5;
  localparam int ST_LEVEL       = 6;
  localparam int ST_RX_VALID    = 7;
  localparam int ST_RX_FULL     = 8;
  localparam int ST_TX_CNT_LSB  = 16;

  // event register fields
  localparam int EV_RX_UF       = 0;
  localparam int EV_TX_OF       = 1;

  // baud divider fields
  localparam int DIV_LSB        = 3;
  localparam int DIV_MSB        = 22;
  localparam int DETECT_BIT     = 31;
  localparam logic [19:0] DIV_RESET = 20'h00000;
  localparam logic [7:0] PATTERN_ASYNC = 8'h55;
  localparam logic [7:0] PATTERN_IRDA  = 8'h00;

  // receive word layout, and the htrans bit that marks a transfer
  localparam int FRAME_ERR_POS  = 15;
  localparam int PARITY_ERR_POS = 14;
  localparam int SECOND_LSB     = 16;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC  = 2'b10
  } sbsr_state_t;

endpackage

/* rtl/sbsr_top.sv */
// register file, receive and transmit buffers of the serial transceiver
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module sbsr_top #(
  parameter int RX_DEPTH = 2,
  parameter int TX_DEPTH = 2
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_frame_valid,
  input  wire logic [8:0]  rx_frame_data,
  input  wire logic        rx_frame_framing_err,
  input  wire logic        rx_frame_parity_err,
  input  wire logic        tx_frame_take,
  input  wire logic        tx_frame_done,
  input  wire logic        tx_shift_idle,
  input  wire logic        baud_measure_valid,
  input  wire logic [19:0] baud_measure,
  output logic             tx_frame_valid,
  output logic      [8:0]  tx_frame_data,
  output logic             tx_on_status,
  output logic             rx_on_status,
  output logic             main_mode,
  output logic             tx_tristated,
  output logic             rx_discard_active,
  output logic      [19:0] baud_div,
  output logic             baud_detect_run,
  output logic      [7:0]  baud_detect_pattern
);
  import sbsr_pkg::*;

  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam logic [RCW-1:0] RX_FULL_CNT = RCW'(RX_DEPTH);
  localparam logic [TCW-1:0] TX_FULL_CNT = TCW'(TX_DEPTH);
  localparam logic [TCW-1:0] TX_HALF_CNT = TCW'(TX_DEPTH / 2);

  // entry: {framing_error_bit, parity_error_bit, data[8:0]}
  typedef struct packed {
    sbsr_state_t                 state;
    logic                        hready;
    logic [31:0]                 hrdata;
    logic [11:0]                 addr;
    logic                        wr;
    logic                        auto_tri;
    logic                        lvl_sel;
    logic                        async_mode;
    logic                        irda;
    logic                        rx_on;
    logic                        tx_on;
    logic                        main_on;
    logic                        discard;
    logic                        tristate;
    logic                        tx_complete;
    logic                        rx_uf;
    logic                        tx_of;
    logic                        baud_on;
    logic [19:0]                 div;
    logic                        baud_run;
    logic [7:0]                  pattern;
    logic [RCW-1:0]              rx_cnt;
    logic [RX_DEPTH-1:0][10:0]   rx_buf;
    logic [TCW-1:0]              tx_cnt;
    logic [TX_DEPTH-1:0][8:0]    tx_buf;
    logic                        tx_valid;
    logic [8:0]                  tx_data;
  } sbsr_regs_t;

  sbsr_regs_t s_r;
  sbsr_regs_t s_nxt;

  // 16-bit extended view of one entry
  function automatic logic [15:0] ext_view(input logic [10:0] e);
    ext_view           = 16'h0000;
    ext_view[8:0]      = e[8:0];
    ext_view[PARITY_ERR_POS] = e[9];
    ext_view[FRAME_ERR_POS]  = e[10];
  endfunction

  function automatic logic [31:0] status_word(input sbsr_regs_t s);
    status_word              = 32'h00000000;
    status_word[ST_RX_ON]    = s.rx_on;
    status_word[ST_TX_ON]    = s.tx_on;
    status_word[ST_MAIN]     = s.main_on;
    status_word[ST_DISCARD]  = s.discard;
    status_word[ST_TRI]      = s.tristate & ~s.auto_tri;
    status_word[ST_TX_COMPLETE] = s.tx_complete;
    status_word[ST_LEVEL]    = s.lvl_sel ? (s.tx_cnt <= TX_HALF_CNT)
                                         : (s.tx_cnt == '0);
    status_word[ST_RX_VALID] = (s.rx_cnt != '0);
    status_word[ST_RX_FULL]  = (s.rx_cnt == RX_FULL_CNT);
    status_word[ST_TX_CNT_LSB +: 2] = 2'(s.tx_cnt);
  endfunction

  logic [31:0] stat_w;
  assign stat_w = status_word(s_r);

  always_comb begin
    logic [1:0]     want;
    logic [RCW-1:0] npop;
    logic [31:0]    rd;
    logic [11:0]    a;
    s_nxt = s_r;
    want  = 2'b00;
    npop  = '0;
    rd    = 32'h00000000;
    a     = s_r.addr;

    // engine takes the head frame into its shift register
    if (tx_frame_take && s_r.tx_cnt != '0) begin
      for (int i = 0; i < TX_DEPTH - 1; i++) begin
        s_nxt.tx_buf[i] = s_r.tx_buf[i+1];
      end
      s_nxt.tx_buf[TX_DEPTH-1] = 9'h000;
      s_nxt.tx_cnt = s_r.tx_cnt - TCW'(1);
    end

    if (s_r.state == ST_ACC) begin
      s_nxt.state  = ST_IDLE;
      s_nxt.hready = 1'b1;
      if (!s_r.wr) begin
        if (a == OFF_CTRL) begin
          rd[CTRL_AUTO_TRI] = s_r.auto_tri;
          rd[CTRL_LVL_SEL]  = s_r.lvl_sel;
          rd[CTRL_ASYNC]    = s_r.async_mode;
          rd[CTRL_IRDA]     = s_r.irda;
        end else if (a == OFF_EVENTS) begin
          // read clears; no event can be raised by this same access
          rd[EV_RX_UF]   = s_r.rx_uf;
          rd[EV_TX_OF]   = s_r.tx_of;
          s_nxt.rx_uf    = 1'b0;
          s_nxt.tx_of    = 1'b0;
        end else if (a == OFF_STATUS) begin
          rd = stat_w;
        end else if (a == OFF_BAUD) begin
          rd[DETECT_BIT]       = s_r.baud_on;
          rd[DIV_MSB:DIV_LSB]  = s_r.div;
        end else if (a == OFF_RX_POPX) begin
          rd[15:0] = ext_view(s_r.rx_buf[0]);
          want     = 2'd1;
        end else if (a == OFF_RX_POPB) begin
          rd[7:0]  = s_r.rx_buf[0][7:0];
          want     = 2'd1;
        end else if (a == OFF_RX_PRX) begin
          rd[15:0] = ext_view(s_r.rx_buf[0]);
          rd[SECOND_LSB +: 16] = ext_view(s_r.rx_buf[1]);
          want     = 2'd2;
        end else if (a == OFF_RX_PRB) begin
          rd[7:0]  = s_r.rx_buf[0][7:0];
          rd[15:8] = s_r.rx_buf[1][7:0];
          want     = 2'd2;
        end else if (a == OFF_RX_PKX) begin
          rd[15:0] = ext_view(s_r.rx_buf[0]);
        end else if (a == OFF_RX_PKPX) begin
          rd[15:0] = ext_view(s_r.rx_buf[0]);
          rd[SECOND_LSB +: 16] = ext_view(s_r.rx_buf[1]);
        end
        s_nxt.hrdata = rd;
      end else begin
        if (a == OFF_CTRL) begin
          s_nxt.auto_tri   = hwdata[CTRL_AUTO_TRI];
          s_nxt.lvl_sel    = hwdata[CTRL_LVL_SEL];
          s_nxt.async_mode = hwdata[CTRL_ASYNC];
          s_nxt.irda       = hwdata[CTRL_IRDA];
        end else if (a == OFF_CMD) begin
          // when enable and disable come together, disable wins
          if (hwdata[CMD_RX_ON])    s_nxt.rx_on    = 1'b1;
          if (hwdata[CMD_RX_OFF])   s_nxt.rx_on    = 1'b0;
          if (hwdata[CMD_TX_ON])    s_nxt.tx_on    = 1'b1;
          if (hwdata[CMD_TX_OFF])   s_nxt.tx_on    = 1'b0;
          if (hwdata[CMD_MAIN_ON])  s_nxt.main_on  = 1'b1;
          if (hwdata[CMD_MAIN_OFF]) s_nxt.main_on  = 1'b0;
          if (hwdata[CMD_DISC_ON])  s_nxt.discard  = 1'b1;
          if (hwdata[CMD_DISC_OFF]) s_nxt.discard  = 1'b0;
          if (hwdata[CMD_TRI_ON])   s_nxt.tristate = 1'b1;
          if (hwdata[CMD_TRI_OFF])  s_nxt.tristate = 1'b0;
        end else if (a == OFF_BAUD) begin
          s_nxt.baud_on = hwdata[DETECT_BIT];
          s_nxt.div     = hwdata[DIV_MSB:DIV_LSB];
        end else if (a == OFF_TX_PUSH) begin
          if (s_nxt.tx_cnt == TX_FULL_CNT) begin
            s_nxt.tx_of = 1'b1;
          end else begin
            s_nxt.tx_buf[s_nxt.tx_cnt] = {1'b0, hwdata[7:0]};
            s_nxt.tx_cnt = s_nxt.tx_cnt + TCW'(1);
            s_nxt.tx_complete = 1'b0;
          end
        end
      end
    end

    // pop only what is there; a short buffer raises underflow
    if (want != 2'b00) begin
      if (RCW'(want) > s_r.rx_cnt) begin
        s_nxt.rx_uf = 1'b1;
        npop = s_r.rx_cnt;
      end else begin
        npop = RCW'(want);
      end
    end
    for (int i = 0; i < RX_DEPTH; i++) begin
      if (i + int'(npop) < RX_DEPTH) begin
        s_nxt.rx_buf[i] = s_r.rx_buf[i + int'(npop)];
      end else begin
        s_nxt.rx_buf[i] = 11'h000;
      end
    end
    s_nxt.rx_cnt = s_r.rx_cnt - npop;

    // discard is sampled at the frame's completion; full buffer drops it
    if (rx_frame_valid && s_r.rx_on && !s_r.discard
        && s_nxt.rx_cnt != RX_FULL_CNT) begin
      s_nxt.rx_buf[s_nxt.rx_cnt] = {rx_frame_framing_err, rx_frame_parity_err, rx_frame_data};
      s_nxt.rx_cnt = s_nxt.rx_cnt + RCW'(1);
    end

    if (tx_frame_done && tx_shift_idle && s_nxt.tx_cnt == '0) begin
      s_nxt.tx_complete = 1'b1;
    end

    // measured rate beats a software write landing in the same cycle
    if (s_r.baud_run && baud_measure_valid) begin
      s_nxt.div = baud_measure;
    end
    s_nxt.baud_run = s_nxt.baud_on & s_nxt.async_mode;
    s_nxt.pattern  = s_nxt.irda ? PATTERN_IRDA : PATTERN_ASYNC;

    if (hsel && hready && (htrans & HTRANS_NONSEQ_BIT) != 2'b00) begin
      s_nxt.state  = ST_ACC;
      s_nxt.hready = 1'b0;
      s_nxt.addr   = {haddr[11:2], 2'b00};
      s_nxt.wr     = hwrite;
    end

    s_nxt.tx_valid = (s_nxt.tx_cnt != '0);
    s_nxt.tx_data  = s_nxt.tx_buf[0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r         <= '0;
      s_r.state   <= ST_IDLE;
      s_r.hready  <= 1'b1;
      s_r.div     <= DIV_RESET;
      s_r.pattern <= PATTERN_ASYNC;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata              = s_r.hrdata;
  assign hreadyout           = s_r.hready;
  assign hresp               = 1'b0;
  assign tx_frame_valid      = s_r.tx_valid;
  assign tx_frame_data       = s_r.tx_data;
  assign tx_on_status        = s_r.tx_on;
  assign rx_on_status        = s_r.rx_on;
  assign main_mode           = s_r.main_on;
  assign tx_tristated        = s_r.tristate;
  assign rx_discard_active   = s_r.discard;
  assign baud_div            = s_r.div;
  assign baud_detect_run     = s_r.baud_run;
  assign baud_detect_pattern = s_r.pattern;

  // checks
  logic acc_rd;
  logic acc_wr;
  assign acc_rd = (s_r.state == ST_ACC) && !s_r.wr;
  assign acc_wr = (s_r.state == ST_ACC) && s_r.wr;

  property p_level;
    @(posedge hclk) disable iff (!hresetn)
      !s_r.lvl_sel |-> (stat_w[ST_LEVEL] == !tx_frame_valid);
  endproperty
  a_level: assert property (p_level)
    else $error("level flag wrong for empty select");

  property p_complete_clear;
    @(posedge hclk) disable iff (!hresetn)
      acc_wr && s_r.addr == OFF_TX_PUSH && s_r.tx_cnt != TX_FULL_CNT |=> !s_r.tx_complete;
  endproperty
  a_complete_clear: assert property (p_complete_clear)
    else $error("complete flag survived a push");

  property p_tri_auto;
    @(posedge hclk) disable iff (!hresetn)
      s_r.auto_tri |-> !stat_w[ST_TRI];
  endproperty
  a_tri_auto: assert property (p_tri_auto)
    else $error("tristated status not zero under auto tristate");

  property p_discard;
    @(posedge hclk) disable iff (!hresetn)
      rx_frame_valid && s_r.discard |=> s_r.rx_cnt <= $past(s_r.rx_cnt);
  endproperty
  a_discard: assert property (p_discard)
    else $error("frame stored while discard active");

  property p_main_on;
    @(posedge hclk) disable iff (!hresetn)
      acc_wr && s_r.addr == OFF_CMD && hwdata[CMD_MAIN_ON] && !hwdata[CMD_MAIN_OFF]
      |=> main_mode && stat_w[ST_MAIN];
  endproperty
  a_main_on: assert property (p_main_on)
    else $error("main status did not follow command");

  property p_detect;
    @(posedge hclk) disable iff (!hresetn)
      s_r.baud_run && baud_measure_valid |=> baud_div == $past(baud_measure);
  endproperty
  a_detect: assert property (p_detect)
    else $error("detected rate not loaded");

  property p_pop_ext;
    @(posedge hclk) disable iff (!hresetn)
      acc_rd && s_r.addr == OFF_RX_POPX && s_r.rx_cnt != '0 && !rx_frame_valid
      |=> hrdata[8:0] == $past(s_r.rx_buf[0][8:0])
          && s_r.rx_cnt == $past(s_r.rx_cnt) - RCW'(1) && hreadyout;
  endproperty
  a_pop_ext: assert property (p_pop_ext)
    else $error("extended pop wrong data or count");

  property p_peek;
    @(posedge hclk) disable iff (!hresetn)
      acc_rd && (s_r.addr == OFF_RX_PKX || s_r.addr == OFF_RX_PKPX)
      && !tx_frame_take |=> s_r.rx_cnt >= $past(s_r.rx_cnt)
                            && s_r.tx_cnt == $past(s_r.tx_cnt);
  endproperty
  a_peek: assert property (p_peek)
    else $error("peek read removed an entry");

  property p_underflow;
    @(posedge hclk) disable iff (!hresetn)
      acc_rd && s_r.addr == OFF_RX_POPB && s_r.rx_cnt == '0 |=> s_r.rx_uf;
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow not flagged");

  property p_overflow;
    @(posedge hclk) disable iff (!hresetn)
      acc_wr && s_r.addr == OFF_TX_PUSH && s_r.tx_cnt == TX_FULL_CNT && !tx_frame_take
      |=> s_r.tx_of && s_r.tx_buf == $past(s_r.tx_buf);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow lost or buffer changed");

  property p_rx_valid;
    @(posedge hclk) disable iff (!hresetn)
      rx_frame_valid && s_r.rx_on && !s_r.discard |=> stat_w[ST_RX_VALID];
  endproperty
  a_rx_valid: assert property (p_rx_valid)
    else $error("receive valid low after a stored frame");

endmodule

`default_nettype wire

/* testbench/sbsr_engine_model.sv */
// frame engine stand-in driving the engine side of the buffer block
`timescale 1ns/100ps
`default_nettype none

module sbsr_engine_model (
  input  wire logic        clk,
  output var  logic        rx_frame_valid,
  output var  logic [8:0]  rx_frame_data,
  output var  logic        rx_frame_framing_err,
  output var  logic        rx_frame_parity_err,
  output var  logic        tx_frame_take,
  output var  logic        tx_frame_done,
  output var  logic        tx_shift_idle,
  output var  logic        baud_measure_valid,
  output var  logic [19:0] baud_measure
);
  initial begin
    rx_frame_valid = 1'h0;
    rx_frame_data = 9'h155;
    rx_frame_framing_err = 1'h0;
    rx_frame_parity_err = 1'h0;
    tx_frame_take = 1'h0;
    tx_frame_done = 1'h0;
    tx_shift_idle = 1'h1;
    baud_measure_valid = 1'h0;
    baud_measure = 20'h5a5a5;
  end

  // each task ends one edge late so the block's state has landed on return
  task automatic rx(input logic [8:0] d, input logic fe, input logic pe);
    @(posedge clk);
    rx_frame_valid <= 1'h1;
    rx_frame_data <= d;
    rx_frame_framing_err <= fe;
    rx_frame_parity_err <= pe;
    @(posedge clk);
    rx_frame_valid <= 1'h0;
    // released lines show junk, never the frame just sent
    rx_frame_data <= ~d;
    rx_frame_framing_err <= ~fe;
    rx_frame_parity_err <= ~pe;
    @(posedge clk);
  endtask

  task automatic take();
    @(posedge clk);
    tx_frame_take <= 1'h1;
    tx_shift_idle <= 1'h0;
    @(posedge clk);
    tx_frame_take <= 1'h0;
    @(posedge clk);
  endtask

  task automatic done();
    @(posedge clk);
    tx_frame_done <= 1'h1;
    tx_shift_idle <= 1'h1;
    @(posedge clk);
    tx_frame_done <= 1'h0;
    @(posedge clk);
  endtask

  task automatic baud(input logic [19:0] v);
    @(posedge clk);
    baud_measure_valid <= 1'h1;
    baud_measure <= v;
    @(posedge clk);
    baud_measure_valid <= 1'h0;
    baud_measure <= ~v;
    @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the serial buffer and status register block
`timescale 1ns/100ps
`default_nettype none

module tb;
  import sbsr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        rx_frame_valid, rx_frame_framing_err, rx_frame_parity_err, tx_frame_take;
  logic        tx_frame_done, tx_shift_idle, baud_measure_valid, tx_frame_valid, tx_on_status;
  logic        rx_on_status, main_mode, tx_tristated, rx_discard_active, baud_detect_run;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  baud_detect_pattern;
  logic [8:0]  rx_frame_data, tx_frame_data;
  logic [19:0] baud_measure, baud_div;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  int          bad_count;
  int          tests_run;

  always #20 hclk = ~hclk;

  // one slave only, so its ready is the bus ready
  sbsr_top #(.RX_DEPTH(2), .TX_DEPTH(2)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .rx_frame_valid, .rx_frame_data, .rx_frame_framing_err,
    .rx_frame_parity_err, .tx_frame_take, .tx_frame_done, .tx_shift_idle, .baud_measure_valid,
    .baud_measure, .tx_frame_valid, .tx_frame_data, .tx_on_status, .rx_on_status,
    .main_mode, .tx_tristated, .rx_discard_active, .baud_div, .baud_detect_run,
    .baud_detect_pattern);

  sbsr_engine_model eng (.clk(hclk), .rx_frame_valid, .rx_frame_data, .rx_frame_framing_err,
    .rx_frame_parity_err, .tx_frame_take, .tx_frame_done, .tx_shift_idle, .baud_measure_valid,
    .baud_measure);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded so a stuck ready cannot hang the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    // response must stay OKAY on every transfer
    chk({30'h0, hresp, hreadyout}, 32'h1);
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    wait_rdy();
    rdat = hrdata;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rdat & m, e);
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    bad_count++;
    give_verdict();
  end

  initial begin
    hclk = 1'h0;
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    rd(OFF_STATUS, 32'h3ffff, 32'h40);
    rd(OFF_BAUD, 32'hffffffff, 32'h0);
    rd(12'h0f0, 32'hffffffff, 32'h0);
    bus(1'h1, OFF_CMD, 32'h15); // receiver, transmitter and main in one write
    rd(OFF_STATUS, 32'h1f, 32'h07);
    chk({29'h0, tx_on_status, rx_on_status, main_mode}, 32'h7);
    bus(1'h1, OFF_CMD, 32'h20);
    rd(OFF_STATUS, 32'h1f, 32'h03);
    bus(1'h1, OFF_CMD, 32'h100);
    rd(OFF_STATUS, 32'h10, 32'h10);
    chk({31'h0, tx_tristated}, 32'h1);
    bus(1'h1, OFF_CTRL, 32'h1);
    rd(OFF_STATUS, 32'h10, 32'h0);
    bus(1'h1, OFF_CTRL, 32'h0);
    bus(1'h1, OFF_CMD, 32'h200);
    rd(OFF_STATUS, 32'h10, 32'h0);
    chk({31'h0, tx_tristated}, 32'h0);
    eng.rx(9'h1a5, 1'h1, 1'h0);
    eng.rx(9'h05a, 1'h0, 1'h1);
    rd(OFF_STATUS, 32'h180, 32'h180);
    rd(OFF_RX_PKX, 32'hffffffff, 32'h81a5);
    rd(OFF_RX_PKPX, 32'hffffffff, 32'h405a81a5);
    rd(OFF_RX_PRX, 32'hffffffff, 32'h405a81a5);
    rd(OFF_STATUS, 32'h180, 32'h0);
    rd(OFF_EVENTS, 32'h3, 32'h0);
    bus(1'h0, OFF_RX_POPB, 32'h0);
    rd(OFF_EVENTS, 32'h3, 32'h1);
    eng.rx(9'h1c3, 1'h0, 1'h0);
    rd(OFF_RX_POPB, 32'hffffffff, 32'hc3);
    eng.rx(9'h1ff, 1'h1, 1'h1);
    rd(OFF_RX_POPX, 32'hffffffff, 32'hc1ff);
    eng.rx(9'h112, 1'h0, 1'h0);
    eng.rx(9'h034, 1'h0, 1'h0);
    rd(OFF_RX_PRB, 32'hffffffff, 32'h3412);
    bus(1'h1, OFF_CMD, 32'h40);
    eng.rx(9'h077, 1'h0, 1'h0);
    rd(OFF_STATUS, 32'h88, 32'h08);
    chk({31'h0, rx_discard_active}, 32'h1);
    bus(1'h1, OFF_CMD, 32'h80);
    // upper bits set on purpose: only the low byte may be queued
    bus(1'h1, OFF_TX_PUSH, 32'hfffff1ab);
    chk({22'h0, tx_frame_valid, tx_frame_data}, 32'h2ab);
    rd(OFF_STATUS, 32'h30060, 32'h10000);
    bus(1'h1, OFF_CTRL, 32'h2);
    rd(OFF_STATUS, 32'h40, 32'h40);
    bus(1'h1, OFF_TX_PUSH, 32'h1cd);
    rd(OFF_STATUS, 32'h30040, 32'h20000);
    bus(1'h1, OFF_TX_PUSH, 32'hee);
    rd(OFF_EVENTS, 32'h3, 32'h2);
    chk({23'h0, tx_frame_data}, 32'hab);
    eng.take();
    chk({23'h0, tx_frame_data}, 32'hcd);
    eng.take();
    rd(OFF_STATUS, 32'h20, 32'h0);
    eng.done();
    rd(OFF_STATUS, 32'h30060, 32'h60);
    bus(1'h1, OFF_TX_PUSH, 32'h11);
    rd(OFF_STATUS, 32'h20, 32'h0);
    bus(1'h1, OFF_BAUD, 32'h0055e6f0);
    rd(OFF_BAUD, 32'hffffffff, 32'h0055e6f0);
    bus(1'h1, OFF_CTRL, 32'h4);
    bus(1'h1, OFF_BAUD, 32'h8055e6f0);
    chk({23'h0, baud_detect_run, baud_detect_pattern}, 32'h155);
    bus(1'h1, OFF_CTRL, 32'hc);
    chk({23'h0, baud_detect_run, baud_detect_pattern}, 32'h100);
    eng.baud(20'h12345);
    rd(OFF_BAUD, 32'hffffffff, 32'h80091a28);
    chk({12'h0, baud_div}, 32'h12345);
    // enable and disable of both directions in one write: disable wins
    bus(1'h1, OFF_CMD, 32'h0f);
    rd(OFF_STATUS, 32'h3, 32'h0);
    chk({30'h0, tx_on_status, rx_on_status}, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
